//--- rtl/prwic_pkg.sv
// Shared constants of the reset, wake and interrupt control block
package prwic_pkg;
	localparam logic [7:0] ADDR_IRQ_L1 = 8'h02;
	localparam logic [7:0] ADDR_IRQ_L1_MASK = 8'h0E;
	localparam logic [7:0] ADDR_IRQ_L2 = 8'h0F;
	localparam logic [7:0] ADDR_RST_CAUSE0 = 8'h20;
	localparam logic [7:0] ADDR_RST_CAUSE1 = 8'h21;
	localparam logic [7:0] ADDR_WAKE_CAUSE = 8'h22;
	localparam logic [7:0] ADDR_MODEM_CTRL = 8'h29;
	localparam logic [7:0] ADDR_MODE = 8'h82;

	localparam logic [7:0] RST_IRQ_L1_MASK = 8'h6A;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// Mode register fields
	localparam int MODE_RESTART_BIT = 0;
	localparam int MODE_OFF_BIT = 1;
	localparam int MODE_CHG_BIT = 4;
	// Modem control fields
	localparam int MODEM_OFF_BIT = 0;
	localparam int MODEM_RST_BIT = 1;
	// Reset cause 0 fields
	localparam int C0_TRIP_BIT = 0;
	localparam int C0_DIE_BIT = 1;
	localparam int C0_BUTTON_BIT = 2;
	localparam int C0_SW_BIT = 4;
	localparam int C0_ADC_LSB = 5;
	// Reset cause 1 fields
	localparam int C1_NORMAL_BIT = 4;
	localparam int C1_OV_LSB = 5;
	localparam int C1_SUPPLY_BIT = 7;
	localparam int C1_RCHG_LSB = 2;
	localparam int C1_VCHG_LSB = 0;
	// Wake cause fields
	localparam int WAKE_BUTTON_BIT = 0;
	// First-level flag positions: thermal, adc, gpio, regulator
	localparam int L1_THRM_BIT = 1;
	localparam int L1_ADC_BIT = 3;
	localparam int L1_GPIO_BIT = 5;
	localparam int L1_VR_BIT = 6;

	// Timing
	localparam int CLK_MHZ = 40;
	localparam int WARN_TO_OFF_US = 400;
	localparam int WARN_TO_OFF_MAX_US = 800;
	localparam int MODEM_OFF_MS = 14;
	localparam int OFF_TO_WARN_MS = 5;
	localparam int IRQ_LATENCY_MS = 1;
	localparam int WARN_TO_OFF_CYC = WARN_TO_OFF_US * CLK_MHZ;
	localparam int MODEM_OFF_CYC = MODEM_OFF_MS * 1000 * CLK_MHZ + 1;
	localparam int OFF_TO_WARN_CYC = OFF_TO_WARN_MS * 1000 * CLK_MHZ + 1;
	localparam int IRQ_LATENCY_CYC = IRQ_LATENCY_MS * 1000 * CLK_MHZ;
	localparam int HOLD_UNIT_CYC = 40000000;

	typedef enum logic [2:0] {PS_OFF, PS_UP, PS_ON, PS_DOWN, PS_RDOWN, PS_RUP} prwic_pwr_e;
	typedef enum logic [1:0] {MS_IDLE, MS_WARN, MS_HOLD, MS_TAIL} prwic_modem_e;
endpackage

//--- rtl/prwic_top.sv
// Reset sources, cause registers, modem reset task and interrupt line
`timescale 1ns/100ps
// Behaviour
// RULE1: Die over-temperature or SoC thermal trip drops all rails at once to mechanical off.
// RULE2: Button held low beyond the four-bit hold limit starts a cold-off sequence.
// RULE3: In cold off a button press is a wake that starts cold boot.
// RULE4: Platform reset low resets only host interfaces; rails and configuration stay.
// RULE5: Writing 1 to mode bit 1 powers rails down through normal sequence.
// RULE6: Writing 1 to mode bit 0 powers down, then powers back up.
// RULE7: Mode bit 4 is read-only charger-on status.
// RULE8: Host writes one modem control bit at a time; acted on at once.
// RULE9: Modem control bit 1 launches the modem reset task; self-clears, reads 0.
// RULE10: Modem control bit 0 drives modem-off pin directly, no task launch.
// RULE11: Task changes to modem-off pin are reflected in modem control bit 0.
// RULE12: Task: warning low, 400-800us, modem-off low over 14ms, release, over 5ms, warning high.
// RULE13: Reset cause registers are on backup power and write-1-to-clear.
// RULE14: Recording a new reset clears stale cause bits in both registers.
// RULE15: Cause 0 bits: ADC 2-0 overtemp, software reset, button, die, SoC trip.
// RULE16: Cause 1 bits: supply removed, rail overvolt 1/0, normal off; OTP reset values.
// RULE17: Cause 1 bits 3:2 select coin charger series resistor.
// RULE18: Cause 1 bits 1:0 select coin charger voltage or off.
// RULE19: Wake bit 0 set by button wake from cold off; write-1-to-clear.
// RULE20: A new wake clears stale wake bits.
// RULE21: Events set second- and first-level flags; unmasked first-level flag raises interrupt.
// RULE22: Interrupt asserts within 1 ms of the event.
// RULE23: Host reads all interrupt registers on seeing interrupt.
// RULE24: Host acknowledges events by writing second-level registers.
// RULE25: Interrupt drops only when all unmasked first-level flags are clear.
// RULE26: Each shutdown sets exactly its own cause bit and clears earlier ones.
module prwic_top #(
	parameter int WARN_CYC = prwic_pkg::WARN_TO_OFF_CYC,
	parameter int MOFF_CYC = prwic_pkg::MODEM_OFF_CYC,
	parameter int TAIL_CYC = prwic_pkg::OFF_TO_WARN_CYC,
	parameter int HOLD_UNIT = prwic_pkg::HOLD_UNIT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic bak_rst_i,
	input wire logic [7:0] otp_cause1_i,
	input wire logic platform_reset_n_i,
	input wire logic power_button_in_n_i,
	input wire logic [3:0] button_hold_limit_i,
	input wire logic die_overtemp_event_i,
	input wire logic soc_thermal_trip_i,
	input wire logic [2:0] adc_overtemp_i,
	input wire logic [1:0] rail_overvolt_i,
	input wire logic supply_removed_i,
	input wire logic suspend_powerdown_ack_i,
	input wire logic seq_down_done_i,
	input wire logic seq_up_done_i,
	input wire logic [3:0] irq_event_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic host_if_reset_o,
	output logic rails_on_o,
	output logic seq_down_o,
	output logic seq_up_o,
	output logic mechanical_off_state_o,
	output logic modem_off_n_o,
	output logic shutdown_warning_n_o,
	output logic [1:0] coin_charge_resistor_o,
	output logic [1:0] coin_charge_voltage_o,
	output logic irq_o
);
	localparam int TW = 20;
	localparam int HW = 26;

	// Refused at elaboration: delays the counters cannot hold
	if (WARN_CYC < 1 || MOFF_CYC < 1 || TAIL_CYC < 1 || HOLD_UNIT < 1)
		$error("prwic_top: delays must be at least one cycle");
	if (WARN_CYC >= 2**TW || MOFF_CYC >= 2**TW || TAIL_CYC >= 2**TW || HOLD_UNIT >= 2**HW)
		$error("prwic_top: delay exceeds counter width");

	prwic_pkg::prwic_pwr_e pwr_q;
	prwic_pkg::prwic_modem_e mst_q;
	logic [7:0] cause0_q;
	logic [7:0] cause1_q;
	logic [7:0] wake_q;
	logic [7:0] l1_mask_q;
	logic [3:0] l2_q;
	logic [1:0] mode_req_q;
	logic modem_off_q;
	logic [TW-1:0] mcnt_q;
	logic [HW-1:0] hunit_q;
	logic [4:0] hcnt_q;
	logic btn_released_q;

	logic wr;
	logic hard_evt;
	logic hold_evt;
	logic wake_evt;
	logic sw_off;
	logic sw_rst;
	logic norm_evt;
	logic record;
	logic [7:0] new_c0;
	logic [7:0] new_c1;
	logic [7:0] l1_flags;

	assign wr = reg_wr_i;
	assign hard_evt = die_overtemp_event_i | soc_thermal_trip_i | (|adc_overtemp_i)
		| (|rail_overvolt_i) | supply_removed_i;
	assign hold_evt = (hcnt_q > {1'b0, button_hold_limit_i}) && !power_button_in_n_i;
	assign wake_evt = pwr_q == prwic_pkg::PS_OFF && btn_released_q && !power_button_in_n_i;
	assign sw_off = mode_req_q[prwic_pkg::MODE_OFF_BIT];
	assign sw_rst = mode_req_q[prwic_pkg::MODE_RESTART_BIT];
	assign norm_evt = suspend_powerdown_ack_i;

	// Shutdown cause codes: one source per soft shutdown, every active source on a hard event
	always_comb
	begin
		new_c0 = 8'h00;
		new_c1 = 8'h00;
		record = 1'b0;
		if (pwr_q != prwic_pkg::PS_OFF && hard_evt)
		begin
			record = 1'b1;
			new_c0[prwic_pkg::C0_TRIP_BIT] = soc_thermal_trip_i; // RULE15
			new_c0[prwic_pkg::C0_DIE_BIT] = die_overtemp_event_i;
			new_c0[prwic_pkg::C0_ADC_LSB +: 3] = adc_overtemp_i;
			new_c1[prwic_pkg::C1_OV_LSB +: 2] = rail_overvolt_i; // RULE16
			new_c1[prwic_pkg::C1_SUPPLY_BIT] = supply_removed_i;
		end
		else if (pwr_q == prwic_pkg::PS_ON)
		begin
			record = 1'b1;
			if (hold_evt)
				new_c0[prwic_pkg::C0_BUTTON_BIT] = 1'b1;
			else if (sw_off || sw_rst)
				new_c0[prwic_pkg::C0_SW_BIT] = 1'b1;
			else if (norm_evt)
				new_c1[prwic_pkg::C1_NORMAL_BIT] = 1'b1;
			else
				record = 1'b0;
		end
	end

	// Power state: hard events bypass the power-down sequence
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			pwr_q <= prwic_pkg::PS_OFF;
		else if (pwr_q != prwic_pkg::PS_OFF && hard_evt)
			pwr_q <= prwic_pkg::PS_OFF; // RULE1
		else
		begin
			unique case (pwr_q)
				prwic_pkg::PS_OFF:
					if (wake_evt)
						pwr_q <= prwic_pkg::PS_UP; // RULE3
				prwic_pkg::PS_UP:
					if (seq_up_done_i)
						pwr_q <= prwic_pkg::PS_ON;
				prwic_pkg::PS_ON:
					if (hold_evt || sw_off || (norm_evt && !sw_rst))
						pwr_q <= prwic_pkg::PS_DOWN; // RULE2 RULE5
					else if (sw_rst)
						pwr_q <= prwic_pkg::PS_RDOWN; // RULE6
				prwic_pkg::PS_DOWN:
					if (seq_down_done_i)
						pwr_q <= prwic_pkg::PS_OFF;
				prwic_pkg::PS_RDOWN:
					if (seq_down_done_i)
						pwr_q <= prwic_pkg::PS_RUP; // RULE6
				prwic_pkg::PS_RUP:
					if (seq_up_done_i)
						pwr_q <= prwic_pkg::PS_ON;
			endcase
		end
	end

	// Pin-level view of the power state
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			rails_on_o <= 1'b0;
			seq_down_o <= 1'b0;
			seq_up_o <= 1'b0;
			mechanical_off_state_o <= 1'b1;
		end
		else
		begin
			rails_on_o <= pwr_q != prwic_pkg::PS_OFF && !hard_evt; // RULE1
			seq_down_o <= (pwr_q == prwic_pkg::PS_DOWN || pwr_q == prwic_pkg::PS_RDOWN) && !hard_evt;
			seq_up_o <= (pwr_q == prwic_pkg::PS_UP || pwr_q == prwic_pkg::PS_RUP) && !hard_evt;
			mechanical_off_state_o <= pwr_q == prwic_pkg::PS_OFF || hard_evt;
		end
	end

	// Warm reset reaches only the host interface
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			host_if_reset_o <= 1'b0;
		else
			host_if_reset_o <= !platform_reset_n_i; // RULE4
	end

	// Button hold timer in units, and release tracking for wake
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || power_button_in_n_i || pwr_q != prwic_pkg::PS_ON)
		begin
			hunit_q <= '0;
			hcnt_q <= '0;
		end
		else if (hunit_q == HW'(HOLD_UNIT - 1))
		begin
			hunit_q <= '0;
			if (hcnt_q != 5'h1F)
				hcnt_q <= hcnt_q + 5'h01; // RULE2
		end
		else
			hunit_q <= hunit_q + HW'(1);
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			btn_released_q <= 1'b0;
		else if (pwr_q != prwic_pkg::PS_OFF)
			btn_released_q <= 1'b0;
		else if (power_button_in_n_i)
			btn_released_q <= 1'b1;
	end

	// Software critical requests, pending until the power state takes them
	always_ff @(posedge mclk_i)
	begin
		if (rst_i || pwr_q != prwic_pkg::PS_ON)
			mode_req_q <= 2'b00;
		else if (record)
			mode_req_q <= 2'b00;
		else if (wr && reg_addr_i == prwic_pkg::ADDR_MODE)
			mode_req_q <= reg_wdata_i[1:0]; // RULE5 RULE6
	end

	// Cause registers live on the backup supply
	always_ff @(posedge mclk_i)
	begin
		if (bak_rst_i)
		begin
			cause0_q <= prwic_pkg::RST_ZERO;
			cause1_q <= otp_cause1_i; // RULE16
		end
		else if (record)
		begin
			cause0_q <= new_c0; // RULE14 RULE26
			cause1_q <= {new_c1[7:4], cause1_q[3:0]};
		end
		else if (wr)
		begin
			if (reg_addr_i == prwic_pkg::ADDR_RST_CAUSE0)
				cause0_q <= cause0_q & ~reg_wdata_i; // RULE13
			if (reg_addr_i == prwic_pkg::ADDR_RST_CAUSE1)
				cause1_q <= {cause1_q[7:4] & ~reg_wdata_i[7:4], reg_wdata_i[3:0]};
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (bak_rst_i)
			wake_q <= prwic_pkg::RST_ZERO;
		else if (wake_evt)
			wake_q <= 8'h01 << prwic_pkg::WAKE_BUTTON_BIT; // RULE19 RULE20
		else if (wr && reg_addr_i == prwic_pkg::ADDR_WAKE_CAUSE)
			wake_q <= wake_q & ~reg_wdata_i; // RULE19
	end

	always_ff @(posedge mclk_i)
	begin
		if (bak_rst_i)
		begin
			coin_charge_resistor_o <= 2'b00;
			coin_charge_voltage_o <= 2'b00;
		end
		else
		begin
			coin_charge_resistor_o <= cause1_q[prwic_pkg::C1_RCHG_LSB +: 2]; // RULE17
			coin_charge_voltage_o <= cause1_q[prwic_pkg::C1_VCHG_LSB +: 2]; // RULE18
		end
	end

	// Modem control bit mirrors the pin; task list drives it too
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			modem_off_q <= 1'b0;
		else if (mst_q == prwic_pkg::MS_WARN && mcnt_q == TW'(WARN_CYC - 1))
			modem_off_q <= 1'b0; // RULE11 RULE12
		else if (mst_q == prwic_pkg::MS_HOLD && mcnt_q == TW'(MOFF_CYC - 1))
			modem_off_q <= 1'b1; // RULE11 RULE12
		else if (wr && reg_addr_i == prwic_pkg::ADDR_MODEM_CTRL && !reg_wdata_i[prwic_pkg::MODEM_RST_BIT])
			modem_off_q <= reg_wdata_i[prwic_pkg::MODEM_OFF_BIT]; // RULE8 RULE10
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			mst_q <= prwic_pkg::MS_IDLE;
			mcnt_q <= '0;
		end
		else
		begin
			unique case (mst_q)
				prwic_pkg::MS_IDLE:
				begin
					mcnt_q <= '0;
					if (wr && reg_addr_i == prwic_pkg::ADDR_MODEM_CTRL && reg_wdata_i[prwic_pkg::MODEM_RST_BIT])
						mst_q <= prwic_pkg::MS_WARN; // RULE9
				end
				prwic_pkg::MS_WARN:
					if (mcnt_q == TW'(WARN_CYC - 1))
					begin
						mcnt_q <= '0;
						mst_q <= prwic_pkg::MS_HOLD;
					end
					else
						mcnt_q <= mcnt_q + TW'(1);
				prwic_pkg::MS_HOLD:
					if (mcnt_q == TW'(MOFF_CYC - 1))
					begin
						mcnt_q <= '0;
						mst_q <= prwic_pkg::MS_TAIL;
					end
					else
						mcnt_q <= mcnt_q + TW'(1);
				prwic_pkg::MS_TAIL:
					if (mcnt_q == TW'(TAIL_CYC - 1))
					begin
						mcnt_q <= '0;
						mst_q <= prwic_pkg::MS_IDLE;
					end
					else
						mcnt_q <= mcnt_q + TW'(1);
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			modem_off_n_o <= 1'b0;
			shutdown_warning_n_o <= 1'b1;
		end
		else
		begin
			modem_off_n_o <= modem_off_q; // RULE10
			shutdown_warning_n_o <= mst_q == prwic_pkg::MS_IDLE; // RULE12
		end
	end

	// Second-level flags; a new event wins over a same-cycle clear
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			l2_q <= 4'h0;
		else
			l2_q <= (l2_q & ~((wr && reg_addr_i == prwic_pkg::ADDR_IRQ_L2) ? reg_wdata_i[3:0] : 4'h0))
				| irq_event_i; // RULE21 RULE24
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			l1_mask_q <= prwic_pkg::RST_IRQ_L1_MASK;
		else if (wr && reg_addr_i == prwic_pkg::ADDR_IRQ_L1_MASK)
			l1_mask_q <= reg_wdata_i & prwic_pkg::RST_IRQ_L1_MASK;
	end

	always_comb
	begin
		l1_flags = 8'h00;
		l1_flags[prwic_pkg::L1_THRM_BIT] = l2_q[0];
		l1_flags[prwic_pkg::L1_ADC_BIT] = l2_q[1];
		l1_flags[prwic_pkg::L1_GPIO_BIT] = l2_q[2];
		l1_flags[prwic_pkg::L1_VR_BIT] = l2_q[3];
		l1_flags = l1_flags & ~l1_mask_q;
	end

	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |l1_flags; // RULE21 RULE22 RULE25
	end

	// Register read port
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				prwic_pkg::ADDR_IRQ_L1: reg_rdata_o <= l1_flags;
				prwic_pkg::ADDR_IRQ_L1_MASK: reg_rdata_o <= l1_mask_q;
				prwic_pkg::ADDR_IRQ_L2: reg_rdata_o <= {4'h0, l2_q};
				prwic_pkg::ADDR_RST_CAUSE0: reg_rdata_o <= cause0_q;
				prwic_pkg::ADDR_RST_CAUSE1: reg_rdata_o <= cause1_q;
				prwic_pkg::ADDR_WAKE_CAUSE: reg_rdata_o <= wake_q;
				prwic_pkg::ADDR_MODEM_CTRL: reg_rdata_o <= {7'h00, modem_off_q}; // RULE9 RULE11
				prwic_pkg::ADDR_MODE: reg_rdata_o <= {3'h0, coin_charge_voltage_o != 2'b00, 2'h0, mode_req_q}; // RULE7
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	hard_off_a: assert property ((die_overtemp_event_i || soc_thermal_trip_i) // RULE1
		|=> !rails_on_o && mechanical_off_state_o) else $error("rails not dropped on critical event");
	restart_seq_a: assert property (pwr_q == prwic_pkg::PS_RDOWN && seq_down_done_i && !hard_evt // RULE6
		|=> pwr_q == prwic_pkg::PS_RUP) else $error("restart did not power back up");
	warm_reset_a: assert property (!platform_reset_n_i && pwr_q != prwic_pkg::PS_OFF && !hard_evt // RULE4
		|=> rails_on_o && host_if_reset_o) else $error("warm reset disturbed rails");
	modem_launch_a: assert property (mst_q == prwic_pkg::MS_IDLE && wr // RULE9
		&& reg_addr_i == prwic_pkg::ADDR_MODEM_CTRL && reg_wdata_i[prwic_pkg::MODEM_RST_BIT]
		|=> ##1 !shutdown_warning_n_o) else $error("modem task not launched");
	modem_pin_a: assert property (wr && reg_addr_i == prwic_pkg::ADDR_MODEM_CTRL // RULE10
		&& !reg_wdata_i[prwic_pkg::MODEM_RST_BIT] && mst_q == prwic_pkg::MS_IDLE
		|-> ##2 modem_off_n_o == $past(reg_wdata_i[prwic_pkg::MODEM_OFF_BIT], 2)) else $error("modem pin not bit");
	warn_gap_a: assert property (mst_q == prwic_pkg::MS_HOLD && $past(mst_q) == prwic_pkg::MS_WARN // RULE12
		|-> !shutdown_warning_n_o && $past(!shutdown_warning_n_o, 2) ##1 !modem_off_n_o)
		else $error("modem off without warning lead");
	cause_one_a: assert property (record && pwr_q == prwic_pkg::PS_ON // RULE14
		|=> $onehot({cause0_q, cause1_q[7:4]})) else $error("more than one cause");
	wake_cause_a: assert property (wake_evt |=> wake_q == 8'h01) else $error("wake cause wrong"); // RULE19
	irq_drop_a: assert property ($fell(irq_o) // RULE25
		|-> $past((l2_q & ~{l1_mask_q[6], l1_mask_q[5], l1_mask_q[3], l1_mask_q[1]}) == 4'h0))
		else $error("irq dropped early");
	irq_rise_a: assert property ((|(irq_event_i & ~{l1_mask_q[6], l1_mask_q[5], l1_mask_q[3], l1_mask_q[1]})) // RULE22
		|-> ##[1:2] irq_o) else $error("irq late");
endmodule

//--- verification/prwic_soc_model.sv
// Behavioural SoC host: register strobes and interrupt service
`timescale 1ns/100ps
module prwic_soc_model (
	input wire logic mclk_i,
	input wire logic [7:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o
);
	// Idle cycles before each strobe, for a slow host
	int idle = 0;
	initial
	begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// One strobe edge; released lines show the inverse so stale values never pass
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] v);
		repeat (idle) @(posedge mclk_i);
		@(posedge mclk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = v;
		reg_wr_o = wr;
		reg_rd_o = !wr;
		@(posedge mclk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~v;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		xfer(1'b1, a, v);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		xfer(1'b0, a, 8'h00);
		v = reg_rdata_i;
	endtask
	// Read both flag levels, then acknowledge every pending second-level bit
	task automatic service(output logic [7:0] l1, output logic [7:0] l2);
		rd(8'h02, l1);
		rd(8'h0F, l2);
		wr(8'h0F, l2);
	endtask
endmodule

//--- verification/testbench.sv
// Self-checking bench for the reset, wake and interrupt control block
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
`define WAITC(c) \
	begin k = 0; while (!(c) && k < 300) begin @(posedge mclk_i); #1; k++; end \
	if (!(c)) begin num_errors++; summarize(); end end
`define WR(a, v) prwic_soc_model_i.wr(a, v);
`define RD(a) prwic_soc_model_i.rd(a, d);
module testbench;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic bak_rst_i = 1'b1;
	logic btn_n = 1'b1;
	logic plt_n = 1'b1;
	logic [3:0] hold_lim = 4'h1;
	logic [7:0] hev = 8'h00;
	logic susp_ack = 1'b0;
	logic dn_done = 1'b0;
	logic up_done = 1'b0;
	logic [3:0] irq_ev = 4'h0;
	logic reg_wr, reg_rd, host_rst, rails_on, seq_dn, seq_up, mech_off, modem_off_n, warn_n, irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, l1, l2;
	logic [1:0] coin_r, coin_v;
	int num_errors = 0;
	int n_compared = 0;
	int k;
	always #12.5 mclk_i = ~mclk_i;
	prwic_top #(.WARN_CYC(5), .MOFF_CYC(8), .TAIL_CYC(6), .HOLD_UNIT(4)) prwic_top_i (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.bak_rst_i(bak_rst_i),
		.otp_cause1_i(8'h05),
		.platform_reset_n_i(plt_n),
		.power_button_in_n_i(btn_n),
		.button_hold_limit_i(hold_lim),
		.die_overtemp_event_i(hev[0]),
		.soc_thermal_trip_i(hev[1]),
		.adc_overtemp_i(hev[4:2]),
		.rail_overvolt_i(hev[6:5]),
		.supply_removed_i(hev[7]),
		.suspend_powerdown_ack_i(susp_ack),
		.seq_down_done_i(dn_done),
		.seq_up_done_i(up_done),
		.irq_event_i(irq_ev),
		.reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata),
		.host_if_reset_o(host_rst),
		.rails_on_o(rails_on),
		.seq_down_o(seq_dn),
		.seq_up_o(seq_up),
		.mechanical_off_state_o(mech_off),
		.modem_off_n_o(modem_off_n),
		.shutdown_warning_n_o(warn_n),
		.coin_charge_resistor_o(coin_r),
		.coin_charge_voltage_o(coin_v),
		.irq_o(irq)
	);
	prwic_soc_model prwic_soc_model_i (
		.mclk_i(mclk_i),
		.reg_rdata_i(reg_rdata),
		.reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd),
		.reg_addr_o(reg_addr),
		.reg_wdata_o(reg_wdata)
	);
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	// One-cycle completion pulse from the rail sequencer
	task automatic seq_done(input logic up);
		tick();
		up_done = up;
		dn_done = !up;
		tick();
		up_done = 1'b0;
		dn_done = 1'b0;
	endtask
	task automatic boot;
		tick();
		btn_n = 1'b0;
		`WAITC(seq_up)
		btn_n = 1'b1;
		seq_done(1'b1);
		`WAITC(rails_on)
		`RD(8'h22)
		`CHK("wake", 8'h01, d)
	endtask
	task automatic t_reset_values;
		`CHK("modem rst", 1'b0, modem_off_n)
		`RD(8'h20)
		`CHK("cause0 rst", 8'h00, d)
		`RD(8'h21)
		`CHK("cause1 otp", 8'h05, d)
		`RD(8'h22)
		`CHK("wake rst", 8'h00, d)
		`RD(8'h40)
		`CHK("unmapped", 8'h00, d)
		for (int v = 0; v < 4; v++)
		begin
			`WR(8'h21, 8'(v * 5))
			tick();
			`CHK("coin r", 2'(v), coin_r)
			`CHK("coin v", 2'(v), coin_v)
			`RD(8'h82)
			`CHK("charger_on_flag", (v != 0) ? 8'h10 : 8'h00, d)
		end
		`WR(8'h82, 8'h00)
		`RD(8'h82)
		`CHK("chg ro", 8'h10, d)
		`WR(8'h21, 8'h05)
	endtask
	task automatic t_hard;
		logic [7:0] e0, e1;
		for (int i = 0; i < 8; i++)
		begin
			e0 = (i == 0) ? 8'h02 : (i == 1) ? 8'h01 : (i < 5) ? 8'h20 << (i - 2) : 8'h00;
			e1 = (i > 4) ? 8'h20 << (i - 5) : 8'h00;
			boot();
			tick();
			hev = 8'h01 << i;
			tick();
			hev = 8'h00;
			`CHK("rails cut", 1'b0, rails_on)
			`CHK("mech off", 1'b1, mech_off)
			`RD(8'h20)
			`CHK("cause0", e0, d)
			`RD(8'h21)
			`CHK("cause1", e1 | 8'h05, d)
		end
		`WR(8'h21, 8'h85)
		`RD(8'h21)
		`CHK("cause1 w1c", 8'h05, d)
	endtask
	task automatic t_restart_off;
		boot();
		`WR(8'h82, 8'h01)
		`WAITC(seq_dn)
		seq_done(1'b0);
		`WAITC(seq_up)
		seq_done(1'b1);
		`WAITC(rails_on)
		`RD(8'h20)
		`CHK("cause sw", 8'h10, d)
		`WR(8'h20, 8'h10)
		`RD(8'h20)
		`CHK("cause0 w1c", 8'h00, d)
		`WR(8'h82, 8'h02)
		`WAITC(seq_dn)
		seq_done(1'b0);
		`WAITC(mech_off)
		`CHK("rails off", 1'b0, rails_on)
	endtask
	task automatic t_hold_norm;
		boot();
		hold_lim = 4'h2;
		btn_n = 1'b0;
		`WAITC(seq_dn)
		`CHK("hold long", 1'b1, k > 8)
		`CHK("hold bound", 1'b1, k < 20)
		btn_n = 1'b1;
		seq_done(1'b0);
		`WAITC(mech_off)
		`RD(8'h20)
		`CHK("cause btn", 8'h04, d)
		boot();
		susp_ack = 1'b1;
		`WAITC(seq_dn)
		susp_ack = 1'b0;
		seq_done(1'b0);
		`WAITC(mech_off)
		`RD(8'h20)
		`CHK("cause0 stale", 8'h00, d)
		`RD(8'h21)
		`CHK("cause norm", 8'h15, d)
	endtask
	task automatic t_modem;
		`WR(8'h29, 8'h01)
		tick();
		`CHK("pin hi", 1'b1, modem_off_n)
		`CHK("no task", 1'b1, warn_n)
		`WR(8'h29, 8'h02)
		`RD(8'h29)
		`CHK("launch rd", 8'h01, d)
		`CHK("warn lo", 1'b0, warn_n)
		`WAITC(!modem_off_n)
		`CHK("warn gap", 1'b1, k >= 3)
		`CHK("warn held", 1'b0, warn_n)
		`RD(8'h29)
		`CHK("bit follows", 8'h00, d)
		`WAITC(modem_off_n)
		`CHK("off long", 1'b1, k >= 5)
		`WAITC(warn_n)
		`CHK("tail long", 1'b1, k >= 4)
		`RD(8'h29)
		`CHK("bit back", 8'h01, d)
	endtask
	task automatic t_irq;
		`WR(8'h0E, 8'h60)
		tick();
		irq_ev = 4'hF;
		tick();
		irq_ev = 4'h0;
		`WAITC(irq)
		`CHK("irq fast", 1'b1, k < 3)
		`RD(8'h02)
		`CHK("l1", 8'h0A, d)
		`RD(8'h0F)
		`CHK("l2", 8'h0F, d)
		`WR(8'h0F, 8'h01)
		repeat (2) tick();
		`CHK("irq held", 1'b1, irq)
		`WR(8'h0F, 8'h0E)
		`WAITC(!irq)
		`CHK("irq drop", 1'b1, k < 3)
		tick();
		irq_ev = 4'h4;
		tick();
		irq_ev = 4'h2;
		repeat (3) tick();
		`CHK("irq on adc", 1'b1, irq)
		irq_ev = 4'h0;
		prwic_soc_model_i.service(l1, l2);
		`CHK("svc l1", 8'h08, l1)
		`CHK("svc l2", 8'h06, l2)
		`WAITC(!irq)
	endtask
	task automatic t_warm;
		boot();
		tick();
		plt_n = 1'b0;
		repeat (2) tick();
		`CHK("host rst", 1'b1, host_rst)
		`CHK("rails kept", 1'b1, rails_on)
		plt_n = 1'b1;
		repeat (2) tick();
		`CHK("host run", 1'b0, host_rst)
		prwic_soc_model_i.idle = 3;
		`RD(8'h0E)
		`CHK("mask kept", 8'h60, d)
		prwic_soc_model_i.idle = 0;
	endtask
	initial
	begin
		repeat (5) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		bak_rst_i = 1'b0;
		t_reset_values();
		t_hard();
		t_restart_off();
		t_hold_norm();
		t_modem();
		t_irq();
		t_warm();
		summarize();
	end
endmodule
